// File: e1_bp_pkg.sv
// Functional notes
// R1: double-rate tx samples on chosen active edge
// R2: tx bit offset from pulse to frame
// R3: tx signaling stays timeslot aligned with data
// R4: rx data edge falling or rising
// R5: rx frame pulse edge falling or rising
// R6: slave/mux rx clock single or double rate
// R7: software sets mux links identically
// R8: tri-state bit floats rx data/signaling
// R9: submode picks line or system timing
// R10: rx frame pulse polarity select
// R11: master pulse marks frame, multiframe or overhead
// R12: code 011 toggles level per multiframe; the code drives a one-bit pulse per multiframe instead
// R13: rx timeslot offset, 31 or 127
// R14: offsets ignored in overhead-pulse master mode
// R15: rx bit offset, signaling stays aligned
// R16: double-rate rx updates on chosen edge
// R17: flag rx pulse spacing off 125 us
// R18: flag tx pulse spacing off 125 us; the code sets this flag only while the tx slave bit or mux mode is set
// R19: flags clear on write of one
// R20: interrupt only for enabled flags
// R21: interrupt holds while enabled flag set
package e1_bp_pkg;
  localparam int unsigned PCLK_KHZ = 25000;
  localparam int unsigned BIT_RATE_KHZ = 2048;
  localparam int unsigned HALF_BIT_CYCLES = PCLK_KHZ / (2 * BIT_RATE_KHZ);
  localparam int unsigned FRAME_US = 125;
  localparam logic [9:0] MASK_FRAME = 10'((FRAME_US * BIT_RATE_KHZ / 1000) - 1);
  localparam logic [9:0] MASK_FRAME_MUX = 10'h3ff;
  localparam logic [3:0] MF_LAST = 4'hf;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_TX_BIT_OFFSET = 8'h45;
  localparam logic [7:0] IDX_RX_OPTIONS = 8'h46;
  localparam logic [7:0] IDX_RX_SUBMODE = 8'h47;
  localparam logic [7:0] IDX_RX_FRAME_PULSE = 8'h48;
  localparam logic [7:0] IDX_RX_TS_OFFSET = 8'h49;
  localparam logic [7:0] IDX_RX_BIT_OFFSET = 8'h4a;
  localparam logic [7:0] IDX_FLAGS = 8'h4b;
  localparam logic [7:0] IDX_IRQ_EN = 8'h4c;
  localparam logic [7:0] IDX_CTRL = 8'h60;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_RX_OPTIONS = 8'h0d;
  localparam logic [7:0] RST_RX_SUBMODE = 8'h01;
  localparam logic [7:0] MASK_BIT_OFFSET = 8'h0f;
  localparam logic [7:0] MASK_RX_OPTIONS = 8'h0f;
  localparam logic [7:0] MASK_SUBMODE = 8'h01;
  localparam logic [7:0] MASK_FRAME_PULSE = 8'h1e;
  localparam logic [7:0] MASK_TS_OFFSET = 8'h7f;
  localparam logic [7:0] MASK_FLAGS = 8'h03;
  localparam logic [7:0] MASK_CTRL = 8'h3f;
  localparam logic [6:0] MASK_TS_NONMUX = 7'h1f;
  // field positions
  localparam int unsigned B_EDGE = 3;
  localparam int unsigned B_BIT_OFFSET_FIELD_HI = 2;
  localparam int unsigned B_DE = 3;
  localparam int unsigned B_FE = 2;
  localparam int unsigned B_CMS = 1;
  localparam int unsigned B_TRI = 0;
  localparam int unsigned B_SUBMODE = 0;
  localparam int unsigned B_FRAME_PULSE_POLARITY = 4;
  localparam int unsigned B_SEL_HI = 3;
  localparam int unsigned B_SEL_LO = 1;
  localparam int unsigned B_RX_FLAG = 1;
  localparam int unsigned B_TX_FLAG = 0;
  localparam int unsigned B_MUX = 0;
  localparam int unsigned B_TX_SLAVE = 1;
  localparam int unsigned B_TX_CMS = 2;
  localparam int unsigned B_TX_DE = 3;
  localparam int unsigned B_TX_FE = 4;
  localparam int unsigned B_TX_FRAME_PULSE_POLARITY = 5;
  // frame pulse selector codes
  localparam logic [2:0] FP_BASIC = 3'h0;
  localparam logic [2:0] FP_CRC_MF = 3'h1;
  localparam logic [2:0] FP_SIG_MF = 3'h2;
  localparam logic [2:0] FP_BOTH_MF = 3'h3;
  localparam logic [2:0] FP_OVERHEAD = 3'h4;
  localparam logic [4:0] TS_SIXTEEN = 5'h10;
  typedef enum logic [1:0] {MODE_MASTER, MODE_SLAVE, MODE_MUX} rx_mode_t;
endpackage : e1_bp_pkg

// File: e1_bp_if.sv
`timescale 1ns/1ps
interface e1_bp_if;
  logic tx_sys_clock_in;
  logic tx_sys_data_in;
  logic tx_sys_signaling_in;
  logic tx_sys_frame_pulse;
  logic rx_clock_dev;
  logic rx_clock_dev_oe;
  logic rx_clock_host;
  logic rx_clock_host_oe;
  logic rx_pulse_dev;
  logic rx_pulse_dev_oe;
  logic rx_pulse_host;
  logic rx_pulse_host_oe;
  logic rx_data_dev;
  logic rx_data_dev_oe;
  logic rx_sig_dev;
  logic rx_sig_dev_oe;
  // resolved wires; undriven pins idle at the pull level
  logic rx_sys_clock;
  logic rx_sys_frame_pulse;
  logic rx_sys_data_out;
  logic rx_sys_signaling_out;
  assign rx_sys_clock = rx_clock_dev_oe ? rx_clock_dev : (rx_clock_host_oe ? rx_clock_host : 1'b0);
  assign rx_sys_frame_pulse = rx_pulse_dev_oe ? rx_pulse_dev : (rx_pulse_host_oe ? rx_pulse_host : 1'b0);
  assign rx_sys_data_out = rx_data_dev_oe ? rx_data_dev : 1'b1;
  assign rx_sys_signaling_out = rx_sig_dev_oe ? rx_sig_dev : 1'b1;
  modport device (
    input tx_sys_clock_in, tx_sys_data_in, tx_sys_signaling_in, tx_sys_frame_pulse,
    input rx_sys_clock, rx_sys_frame_pulse,
    output rx_clock_dev, rx_clock_dev_oe, rx_pulse_dev, rx_pulse_dev_oe,
    output rx_data_dev, rx_data_dev_oe, rx_sig_dev, rx_sig_dev_oe
  );
  modport host (
    output tx_sys_clock_in, tx_sys_data_in, tx_sys_signaling_in, tx_sys_frame_pulse,
    output rx_clock_host, rx_clock_host_oe, rx_pulse_host, rx_pulse_host_oe,
    input rx_sys_clock, rx_sys_frame_pulse, rx_sys_data_out, rx_sys_signaling_out
  );
endinterface : e1_bp_if

// File: e1_bp_device.sv
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
module e1_bp_device
  import e1_bp_pkg::*;
#(
  parameter int unsigned HALF_DIV = HALF_BIT_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  e1_bp_if.device link,
  input wire logic [7:0] rx_payload,
  input wire logic [3:0] rx_sig_nibble,
  output logic [6:0] rx_ts_index,
  output logic [7:0] tx_byte,
  output logic [7:0] tx_sig_byte,
  output logic tx_byte_valid,
  output logic irq
);
  localparam int unsigned NS = 6;
  localparam int unsigned S_TCK = 5;
  localparam int unsigned S_TD = 4;
  localparam int unsigned S_TS = 3;
  localparam int unsigned S_TFP = 2;
  localparam int unsigned S_RCK = 1;
  localparam int unsigned S_RFP = 0;

  logic [7:0] tx_bit_offset_ctrl, rx_backplane_options, rx_backplane_submode, rx_frame_pulse_ctrl;
  logic [7:0] rx_timeslot_offset, rx_bit_offset_ctrl, frame_pulse_change_flags, frame_pulse_irq_enable;
  logic [7:0] backplane_ctrl;
  logic [NS-1:0] pin_raw, sync1, sync2, sync3;
  logic [7:0] rd;
  logic hit;
  logic [1:0] flag_set;

  // every link input crosses two flops before use; the third is for edges
  assign pin_raw = {link.tx_sys_clock_in, link.tx_sys_data_in, link.tx_sys_signaling_in,
                    link.tx_sys_frame_pulse, link.rx_sys_clock, link.rx_sys_frame_pulse};
  for (genvar i = 0; i < NS; i++) begin : g_sync
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        sync1[i] <= 1'b0;
        sync2[i] <= 1'b0;
        sync3[i] <= 1'b0;
      end else begin
        sync1[i] <= pin_raw[i];
        sync2[i] <= sync1[i];
        sync3[i] <= sync2[i];
      end
    end
  end

  // register read mux and decode
  always_comb begin
    hit = (paddr[11:10] == 2'h0);
    rd = RST_ZERO;
    case (paddr[9:2])
      IDX_TX_BIT_OFFSET: rd = tx_bit_offset_ctrl;
      IDX_RX_OPTIONS: rd = rx_backplane_options;
      IDX_RX_SUBMODE: rd = rx_backplane_submode;
      IDX_RX_FRAME_PULSE: rd = rx_frame_pulse_ctrl;
      IDX_RX_TS_OFFSET: rd = rx_timeslot_offset;
      IDX_RX_BIT_OFFSET: rd = rx_bit_offset_ctrl;
      IDX_FLAGS: rd = frame_pulse_change_flags;
      IDX_IRQ_EN: rd = frame_pulse_irq_enable;
      IDX_CTRL: rd = backplane_ctrl;
      default: hit = 1'b0;
    endcase
  end

  wire wr_en = psel & penable & pready & pwrite & hit;

  // apb answer: data latched in setup, one access cycle, no waits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else if (psel & ~penable) begin
      pready <= 1'b1;
      prdata <= {24'h0, rd};
      pslverr <= ~hit;
    end else if (penable & pready) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // plain read/write configuration; reserved bits are never stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_bit_offset_ctrl <= RST_ZERO;
      rx_backplane_options <= RST_RX_OPTIONS;
      rx_backplane_submode <= RST_RX_SUBMODE;
      rx_frame_pulse_ctrl <= RST_ZERO;
      rx_timeslot_offset <= RST_ZERO;
      rx_bit_offset_ctrl <= RST_ZERO;
      frame_pulse_irq_enable <= RST_ZERO;
      backplane_ctrl <= RST_ZERO;
    end else if (wr_en) begin
      case (paddr[9:2])
        IDX_TX_BIT_OFFSET: tx_bit_offset_ctrl <= pwdata[7:0] & MASK_BIT_OFFSET;
        IDX_RX_OPTIONS: rx_backplane_options <= pwdata[7:0] & MASK_RX_OPTIONS;
        IDX_RX_SUBMODE: rx_backplane_submode <= pwdata[7:0] & MASK_SUBMODE;
        IDX_RX_FRAME_PULSE: rx_frame_pulse_ctrl <= pwdata[7:0] & MASK_FRAME_PULSE;
        IDX_RX_TS_OFFSET: rx_timeslot_offset <= pwdata[7:0] & MASK_TS_OFFSET;
        IDX_RX_BIT_OFFSET: rx_bit_offset_ctrl <= pwdata[7:0] & MASK_BIT_OFFSET;
        IDX_IRQ_EN: frame_pulse_irq_enable <= pwdata[7:0] & MASK_FLAGS;
        IDX_CTRL: backplane_ctrl <= pwdata[7:0] & MASK_CTRL;
        default: ;
      endcase
    end
  end

  // sticky flags; a new event beats a same-cycle clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_pulse_change_flags <= RST_ZERO;
    end else begin
      frame_pulse_change_flags <= ((wr_en && paddr[9:2] == IDX_FLAGS) ?
        (frame_pulse_change_flags & ~pwdata[7:0]) : frame_pulse_change_flags) | {6'h0, flag_set}; // [R19]
    end
  end

  // interrupt level follows enabled flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) irq <= 1'b0;
    else irq <= |(frame_pulse_change_flags & frame_pulse_irq_enable); // [R20] [R21]
  end

  wire mux_mode = backplane_ctrl[B_MUX];
  wire [9:0] frame_mask = mux_mode ? MASK_FRAME_MUX : MASK_FRAME;

  // ---- transmit side, always clocked by the system side here
  wire tck_rise = sync2[S_TCK] & ~sync3[S_TCK];
  wire tck_fall = ~sync2[S_TCK] & sync3[S_TCK];
  wire tx_data_edge = backplane_ctrl[B_TX_DE] ? tck_rise : tck_fall;
  wire tx_frame_edge = backplane_ctrl[B_TX_FE] ? tck_rise : tck_fall;
  wire tx_fp_active = sync2[S_TFP] ^ backplane_ctrl[B_TX_FRAME_PULSE_POLARITY];
  logic tx_phase, tx_fp_prev, tx_seen;
  logic [9:0] tx_since;
  logic [7:0] tx_shift, tx_sig_shift;
  wire tx_take = tx_data_edge & (~backplane_ctrl[B_TX_CMS] | (tx_phase == tx_bit_offset_ctrl[B_EDGE])); // [R1]
  wire tx_fp_start = tx_frame_edge & tx_fp_active & ~tx_fp_prev;
  wire [9:0] tx_pos = 10'(tx_since - {7'h0, tx_bit_offset_ctrl[B_BIT_OFFSET_FIELD_HI:0]}) & frame_mask; // [R2]
  wire tx_check = backplane_ctrl[B_TX_SLAVE] | mux_mode;

  // transmit bit counter, phase and pulse spacing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_phase <= 1'b0;
      tx_fp_prev <= 1'b0;
      tx_seen <= 1'b0;
      tx_since <= 10'h0;
    end else begin
      if (tx_frame_edge) tx_fp_prev <= tx_fp_active;
      if (tx_fp_start) begin
        tx_seen <= 1'b1;
        tx_phase <= tx_data_edge;
        tx_since <= tx_take ? 10'h1 : 10'h0;
      end else if (tx_data_edge) begin
        tx_phase <= ~tx_phase;
        if (tx_take) tx_since <= 10'(tx_since + 10'h1) & frame_mask;
      end
    end
  end
  assign flag_set[B_TX_FLAG] = tx_fp_start & tx_seen & tx_check & (tx_since != 10'h0); // [R18]

  // data and signaling shift together so slots stay paired
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_shift <= 8'h0;
      tx_sig_shift <= 8'h0;
      tx_byte <= 8'h0;
      tx_sig_byte <= 8'h0;
      tx_byte_valid <= 1'b0;
    end else begin
      tx_byte_valid <= 1'b0;
      if (tx_take) begin
        tx_shift <= {tx_shift[6:0], sync2[S_TD]};
        tx_sig_shift <= {tx_sig_shift[6:0], sync2[S_TS]}; // [R3]
        if (tx_pos[2:0] == 3'h7) begin
          tx_byte <= {tx_shift[6:0], sync2[S_TD]};
          tx_sig_byte <= {tx_sig_shift[6:0], sync2[S_TS]}; // [R3]
          tx_byte_valid <= 1'b1;
        end
      end
    end
  end

  // ---- receive side
  rx_mode_t rx_mode;
  always_comb begin
    if (mux_mode) rx_mode = MODE_MUX;
    else if (rx_backplane_submode[B_SUBMODE]) rx_mode = MODE_SLAVE; // [R9]
    else rx_mode = MODE_MASTER;
  end
  wire master = (rx_mode == MODE_MASTER);
  logic [$clog2(HALF_DIV+1)-1:0] rdiv;
  logic rclk_q, rx_phase, rx_fp_prev, rx_seen, fp_level;
  logic [9:0] rx_cnt;
  logic [3:0] rx_mf;
  wire rdiv_tick = (rdiv == ($clog2(HALF_DIV+1))'(HALF_DIV - 1));
  wire rx_rise = master ? (rdiv_tick & ~rclk_q) : (sync2[S_RCK] & ~sync3[S_RCK]);
  wire rx_fall = master ? (rdiv_tick & rclk_q) : (~sync2[S_RCK] & sync3[S_RCK]);
  wire rx_data_edge = rx_backplane_options[B_DE] ? rx_rise : rx_fall; // [R4]
  wire rx_frame_edge = rx_backplane_options[B_FE] ? rx_rise : rx_fall; // [R5]
  wire rx_double = ~master & rx_backplane_options[B_CMS]; // [R6]
  wire rx_upd = rx_data_edge & (~rx_double | (rx_phase == rx_bit_offset_ctrl[B_EDGE])); // [R16]
  wire rx_fp_in = sync2[S_RFP] ^ rx_frame_pulse_ctrl[B_FRAME_PULSE_POLARITY]; // [R10]
  wire rx_fp_start = ~master & rx_frame_edge & rx_fp_in & ~rx_fp_prev;
  wire [2:0] fp_sel = rx_frame_pulse_ctrl[B_SEL_HI:B_SEL_LO];
  wire no_offset = master & (fp_sel == FP_OVERHEAD); // [R14]
  wire [6:0] ts_off = rx_timeslot_offset[6:0] & (mux_mode ? MASK_TS_OFFSET[6:0] : MASK_TS_NONMUX); // [R13]
  wire [9:0] rx_off = no_offset ? 10'h0 : 10'({ts_off, rx_bit_offset_ctrl[B_BIT_OFFSET_FIELD_HI:0]}); // [R15]
  wire [9:0] rx_pos = 10'(rx_cnt - rx_off) & frame_mask;
  wire [9:0] rx_next = 10'(rx_pos + 10'h1) & frame_mask;

  // clock divided down from pclk when the device is clock master
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdiv <= '0;
      rclk_q <= 1'b0;
    end else if (rdiv_tick) begin
      rdiv <= '0;
      rclk_q <= ~rclk_q;
    end else begin
      rdiv <= rdiv + 1'b1;
    end
  end

  // receive bit and multiframe counters, pulse spacing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_cnt <= 10'h0;
      rx_mf <= 4'h0;
      rx_phase <= 1'b0;
      rx_fp_prev <= 1'b0;
      rx_seen <= 1'b0;
    end else begin
      if (rx_frame_edge) rx_fp_prev <= rx_fp_in;
      if (rx_fp_start) begin
        rx_seen <= 1'b1;
        rx_phase <= rx_data_edge;
        rx_cnt <= rx_upd ? 10'h1 : 10'h0;
      end else if (rx_data_edge) begin
        rx_phase <= ~rx_phase;
        if (rx_upd) begin
          rx_cnt <= 10'(rx_cnt + 10'h1) & frame_mask;
          if (rx_cnt == frame_mask) rx_mf <= (rx_mf == MF_LAST) ? 4'h0 : 4'(rx_mf + 4'h1);
        end
      end
    end
  end
  assign flag_set[B_RX_FLAG] = rx_fp_start & rx_seen & (rx_cnt != 10'h0); // [R17]

  // data and signaling leave on the update edge, offset from the pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link.rx_data_dev <= 1'b1;
      link.rx_sig_dev <= 1'b1;
      rx_ts_index <= 7'h0;
    end else if (rx_upd) begin
      link.rx_data_dev <= rx_payload[~rx_pos[2:0]];
      link.rx_sig_dev <= rx_pos[2] ? rx_sig_nibble[~rx_pos[1:0]] : 1'b0; // [R15]
      rx_ts_index <= rx_next[9:3];
    end
  end

  // master frame pulse; code 011 is a one-bit pulse per multiframe, like 001 and 010
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fp_level <= 1'b0;
    end else if (master & rx_frame_edge) begin
      case (fp_sel) // [R11]
        FP_BASIC: fp_level <= (rx_cnt == 10'h0);
        FP_CRC_MF: fp_level <= (rx_cnt == 10'h0) && (rx_mf == 4'h0);
        FP_SIG_MF: fp_level <= (rx_cnt == 10'h0) && (rx_mf == 4'h0);
        FP_BOTH_MF: begin
          if (rx_cnt == 10'h0 && rx_mf == 4'h0) fp_level <= 1'b1; // [R12]
          else if (rx_cnt == 10'h1 && rx_mf == 4'h0) fp_level <= 1'b0; // [R12]
        end
        FP_OVERHEAD: fp_level <= (rx_cnt[7:3] == 5'h0) || (rx_cnt[7:3] == TS_SIXTEEN);
        default: fp_level <= 1'b0;
      endcase
    end
  end

  // pin drives and enables
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link.rx_clock_dev <= 1'b0;
      link.rx_clock_dev_oe <= 1'b0;
      link.rx_pulse_dev <= 1'b0;
      link.rx_pulse_dev_oe <= 1'b0;
      link.rx_data_dev_oe <= 1'b0;
      link.rx_sig_dev_oe <= 1'b0;
    end else begin
      link.rx_clock_dev <= rclk_q;
      link.rx_clock_dev_oe <= master; // [R9]
      link.rx_pulse_dev <= fp_level ^ rx_frame_pulse_ctrl[B_FRAME_PULSE_POLARITY]; // [R10]
      link.rx_pulse_dev_oe <= master;
      link.rx_data_dev_oe <= ~rx_backplane_options[B_TRI]; // [R8]
      link.rx_sig_dev_oe <= ~rx_backplane_options[B_TRI]; // [R8]
    end
  end
endmodule : e1_bp_device

// File: e1_bp_host.sv
`timescale 1ns/1ps
module e1_bp_host
  import e1_bp_pkg::*;
#(
  parameter int unsigned HALF_DIV = HALF_BIT_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  e1_bp_if.host link,
  input wire logic cfg_mux,
  input wire logic cfg_tx_double,
  input wire logic cfg_tx_rising,
  input wire logic cfg_tx_fp_low,
  input wire logic cfg_rx_slave,
  input wire logic cfg_rx_double,
  input wire logic cfg_rx_rising,
  input wire logic cfg_rx_fp_low,
  input wire logic [7:0] tx_byte_in,
  input wire logic [3:0] tx_sig_nibble,
  output logic [6:0] tx_slot,
  output logic [7:0] rx_byte,
  output logic rx_byte_valid
);
  localparam int unsigned DW = $clog2(HALF_DIV + 1);
  wire [9:0] frame_mask = cfg_mux ? MASK_FRAME_MUX : MASK_FRAME;
  logic [DW-1:0] tdiv, rdiv;
  logic [1:0] tph, rph;
  logic [9:0] tcnt, rcnt;
  logic [2:0] s1, s2;
  logic s3_clk, fp_prev;
  logic [2:0] rbit;
  logic [7:0] rshift;

  // double rate halves the half-period; R6 rate and R9 timing come from here
  wire [DW-1:0] t_half = cfg_tx_double ? DW'(HALF_DIV / 2 - 1) : DW'(HALF_DIV - 1);
  wire [DW-1:0] r_half = cfg_rx_double ? DW'(HALF_DIV / 2 - 1) : DW'(HALF_DIV - 1);
  wire t_tick = (tdiv == t_half);
  wire r_tick = (rdiv == r_half);
  wire t_wrap = t_tick & (tph == (cfg_tx_double ? 2'h3 : 2'h1));
  wire r_wrap = r_tick & (rph == (cfg_rx_double ? 2'h3 : 2'h1));
  wire [9:0] tnext = 10'(tcnt + 10'h1) & frame_mask;

  // transmit generator: bit starts with clock at its idle level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tdiv <= '0;
      tph <= 2'h0;
      tcnt <= 10'h0;
      tx_slot <= 7'h0;
      link.tx_sys_clock_in <= 1'b0;
      link.tx_sys_data_in <= 1'b0;
      link.tx_sys_signaling_in <= 1'b0;
      link.tx_sys_frame_pulse <= 1'b0;
    end else begin
      tdiv <= t_tick ? '0 : tdiv + 1'b1;
      if (t_tick) begin
        tph <= t_wrap ? 2'h0 : tph + 2'h1;
        link.tx_sys_clock_in <= (t_wrap ? 1'b0 : tph[0] ^ 1'b1) ^ ~cfg_tx_rising;
      end
      if (t_wrap) begin
        tcnt <= tnext;
        tx_slot <= tnext[9:3];
        link.tx_sys_data_in <= tx_byte_in[~tcnt[2:0]];
        link.tx_sys_signaling_in <= tcnt[2] ? tx_sig_nibble[~tcnt[1:0]] : 1'b0; // [R3]
        link.tx_sys_frame_pulse <= (tcnt == 10'h0) ^ cfg_tx_fp_low;
      end
    end
  end

  // receive clock and pulse when the device is clock slave
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdiv <= '0;
      rph <= 2'h0;
      rcnt <= 10'h0;
      link.rx_clock_host <= 1'b0;
      link.rx_clock_host_oe <= 1'b0;
      link.rx_pulse_host <= 1'b0;
      link.rx_pulse_host_oe <= 1'b0;
    end else begin
      link.rx_clock_host_oe <= cfg_rx_slave; // [R9]
      link.rx_pulse_host_oe <= cfg_rx_slave;
      rdiv <= r_tick ? '0 : rdiv + 1'b1;
      if (r_tick) begin
        rph <= r_wrap ? 2'h0 : rph + 2'h1;
        link.rx_clock_host <= ~(r_wrap ? 1'b0 : rph[0] ^ 1'b1) ^ ~cfg_rx_rising;
      end
      if (r_wrap) begin
        rcnt <= 10'(rcnt + 10'h1) & frame_mask;
        link.rx_pulse_host <= (rcnt == 10'h0) ^ cfg_rx_fp_low;
      end
    end
  end

  // device outputs cross two flops before use
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1 <= 3'h0;
      s2 <= 3'h0;
      s3_clk <= 1'b0;
    end else begin
      s1 <= {link.rx_sys_clock, link.rx_sys_frame_pulse, link.rx_sys_data_out};
      s2 <= s1;
      s3_clk <= s2[2];
    end
  end

  // sample on the edge opposite the device update edge
  wire samp_edge = cfg_rx_rising ? (~s2[2] & s3_clk) : (s2[2] & ~s3_clk);
  wire fp_act = s2[1] ^ cfg_rx_fp_low;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fp_prev <= 1'b0;
      rbit <= 3'h0;
      rshift <= 8'h0;
      rx_byte <= 8'h0;
      rx_byte_valid <= 1'b0;
    end else begin
      rx_byte_valid <= 1'b0;
      if (samp_edge) begin
        fp_prev <= fp_act;
        rshift <= {rshift[6:0], s2[0]};
        rbit <= (fp_act & ~fp_prev) ? 3'h1 : rbit + 3'h1;
        if (rbit == 3'h7 && !(fp_act & ~fp_prev)) begin
          rx_byte <= {rshift[6:0], s2[0]};
          rx_byte_valid <= 1'b1;
        end
      end
    end
  end
endmodule : e1_bp_host

// File: e1_bp_chk.sv
`timescale 1ns/1ps
module e1_bp_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tx_sys_signaling_in,
  input wire logic rx_clock_dev,
  input wire logic rx_clock_dev_oe,
  input wire logic rx_clock_host_oe,
  input wire logic rx_pulse_dev_oe,
  input wire logic rx_pulse_host_oe,
  input wire logic rx_data_dev,
  input wire logic rx_data_dev_oe,
  input wire logic rx_sig_dev,
  input wire logic rx_sig_dev_oe
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // hold figures assume HALF_DIV of 4, a bit of 8 cycles
  property p_tri_pair; rx_data_dev_oe == rx_sig_dev_oe; endproperty
  property p_clk_owner; !(rx_clock_dev_oe && rx_clock_host_oe); endproperty
  property p_fp_owner; !(rx_pulse_dev_oe && rx_pulse_host_oe); endproperty
  property p_master_pair; rx_clock_dev_oe == rx_pulse_dev_oe; endproperty
  property p_data_hold; $changed(rx_data_dev) && rx_data_dev_oe |=> $stable(rx_data_dev) [*3]; endproperty
  property p_sig_hold; $changed(rx_sig_dev) && rx_sig_dev_oe |=> $stable(rx_sig_dev) [*3]; endproperty
  property p_clk_half; $changed(rx_clock_dev) && rx_clock_dev_oe |=> $stable(rx_clock_dev) [*3]; endproperty
  property p_tx_sig_hold; $changed(tx_sys_signaling_in) |=> $stable(tx_sys_signaling_in) [*3]; endproperty
  a_tri_pair: assert property (p_tri_pair) else $error("enables differ");
  a_clk_owner: assert property (p_clk_owner) else $error("clock driven twice");
  a_fp_owner: assert property (p_fp_owner) else $error("pulse driven twice");
  a_master_pair: assert property (p_master_pair) else $error("clock and pulse owners differ");
  a_data_hold: assert property (p_data_hold) else $error("data bit too short");
  a_sig_hold: assert property (p_sig_hold) else $error("signaling bit too short");
  a_clk_half: assert property (p_clk_half) else $error("clock half period short");
  a_tx_sig_hold: assert property (p_tx_sig_hold) else $error("tx signaling bit short");
  c_data_on: cover property (rx_data_dev_oe);
  c_host_clock: cover property (rx_clock_host_oe);
  c_host_pulse: cover property (rx_pulse_host_oe);
  c_dev_clock: cover property (rx_clock_dev_oe);
endmodule : e1_bp_chk

// File: e1_backplane_system_interface_bench.sv
`timescale 1ns/1ps
module e1_backplane_system_interface_bench;
  import e1_bp_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, irq, tx_byte_valid, rx_byte_valid;
  logic [7:0] tx_byte, tx_sig_byte, rx_byte, cfg = 8'h0a;
  logic [3:0] tx_sig = 4'h6;
  int failures = 0, total_checks = 0;
  e1_bp_if link();
  e1_bp_device #(.HALF_DIV(4)) e1_bp_device_i (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link(link), .rx_payload(8'ha5), .rx_sig_nibble(4'h9), .rx_ts_index(), .tx_byte(tx_byte),
    .tx_sig_byte(tx_sig_byte), .tx_byte_valid(tx_byte_valid), .irq(irq));
  // cfg bits: mux, tx dbl, tx rise, tx low, rx slave, rx dbl, rx rise, rx low
  e1_bp_host #(.HALF_DIV(4)) e1_bp_host_i (.pclk(pclk), .presetn(presetn), .link(link), .cfg_mux(cfg[7]),
    .cfg_tx_double(cfg[6]), .cfg_tx_rising(cfg[5]), .cfg_tx_fp_low(cfg[4]), .cfg_rx_slave(cfg[3]),
    .cfg_rx_double(cfg[2]), .cfg_rx_rising(cfg[1]), .cfg_rx_fp_low(cfg[0]), .tx_byte_in(8'h3c),
    .tx_sig_nibble(tx_sig), .tx_slot(), .rx_byte(rx_byte), .rx_byte_valid(rx_byte_valid));
  e1_bp_chk e1_bp_chk_i (.pclk(pclk), .presetn(presetn), .tx_sys_signaling_in(link.tx_sys_signaling_in),
    .rx_clock_dev(link.rx_clock_dev), .rx_clock_dev_oe(link.rx_clock_dev_oe),
    .rx_clock_host_oe(link.rx_clock_host_oe), .rx_pulse_dev_oe(link.rx_pulse_dev_oe),
    .rx_pulse_host_oe(link.rx_pulse_host_oe), .rx_data_dev(link.rx_data_dev),
    .rx_data_dev_oe(link.rx_data_dev_oe), .rx_sig_dev(link.rx_sig_dev), .rx_sig_dev_oe(link.rx_sig_dev_oe));
  initial begin
    forever #20 pclk = ~pclk;
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // one apb transfer; read data and error taken at the pready edge only
  task apb(input logic w, input logic [7:0] idx, input logic [7:0] wd, input logic [7:0] exp, input logic err);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    if (!w) chk(prdata, {24'h0, exp});
    chk({31'h0, pslverr}, {31'h0, err});
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  // skip partial bytes at start; checks the third whole one
  task wait_byte(input bit rx);
    repeat (3) do @(posedge pclk); while ((rx ? rx_byte_valid : tx_byte_valid) !== 1'b1);
  endtask : wait_byte
  task summarize;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : summarize
  initial begin
    repeat (100000) @(posedge pclk);
    failures++;
    summarize();
  end
  initial begin
    logic [7:0] rst_val [8];
    rst_val = '{8'h00, 8'h0d, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 6; i++) apb(0, 8'h45 + 8'(i), 8'h00, rst_val[i], 0);
    apb(0, 8'h4b, 8'h00, 8'h00, 0);
    apb(1, 8'h45, 8'hff, 8'h00, 0);
    apb(0, 8'h45, 8'h00, 8'h0f, 0);
    apb(1, 8'h49, 8'hff, 8'h00, 0);
    apb(0, 8'h49, 8'h00, 8'h7f, 0);
    apb(1, 8'h45, 8'h00, 8'h00, 0);
    apb(1, 8'h49, 8'h00, 8'h00, 0);
    apb(0, 8'h70, 8'h00, 8'h00, 1);
    chk({31'h0, link.rx_sys_data_out}, 32'h1);
    apb(1, 8'h46, 8'h0c, 8'h00, 0);
    wait_byte(1);
    chk({24'h0, rx_byte}, 32'ha5);
    wait_byte(0);
    chk({24'h0, tx_byte}, 32'h3c);
    chk({24'h0, tx_sig_byte}, {28'h0, tx_sig});
    // device expects mux frame length, host keeps basic frames
    apb(1, 8'h60, 8'h01, 8'h00, 0);
    repeat (5000) @(posedge pclk);
    apb(0, 8'h4b, 8'h00, 8'h03, 0);
    chk({31'h0, irq}, 32'h0);
    apb(1, 8'h4b, 8'h00, 8'h00, 0);
    apb(0, 8'h4b, 8'h00, 8'h03, 0);
    apb(1, 8'h4c, 8'h02, 8'h00, 0);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h1);
    apb(1, 8'h60, 8'h00, 8'h00, 0);
    repeat (3000) @(posedge pclk);
    apb(1, 8'h4b, 8'h03, 8'h00, 0);
    apb(0, 8'h4b, 8'h00, 8'h00, 0);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    // float data, drop host timing, then let the device be clock master
    apb(1, 8'h46, 8'h0d, 8'h00, 0);
    cfg <= 8'h02;
    repeat (8) @(posedge pclk);
    apb(1, 8'h47, 8'h00, 8'h00, 0);
    apb(1, 8'h46, 8'h0c, 8'h00, 0);
    chk({31'h0, link.rx_clock_dev_oe}, 32'h1);
    // one whole frame so the host realigns on the device pulse
    repeat (2100) @(posedge pclk);
    wait_byte(1);
    chk({24'h0, rx_byte}, 32'ha5);
    summarize();
  end
endmodule : e1_backplane_system_interface_bench
